// file: core/dtm_defs.vh
// Constants for the DMA bus trace messaging block
`ifndef DTM_DEFS_VH
`define DTM_DEFS_VH
`define DTM_TC_WRITE 6'h05
`define DTM_TC_READ 6'h06
`define DTM_TC_ERROR 6'h08
`define DTM_TC_SYNC_WRITE 6'h0D
`define DTM_TC_SYNC_READ 6'h0E
`define DTM_TC_WATCH 6'h0F
`define DTM_EC_DATA 5'h02
`define DTM_EC_WATCH 5'h06
`define DTM_EC_BOTH 5'h08
`define DTM_SZ_BYTE 3'h0
`define DTM_SZ_HALF 3'h1
`define DTM_SZ_WORD 3'h2
`define DTM_SZ_DOUBLE 3'h3
`define DTM_WHIT_ONE 4'h4
`define DTM_WHIT_TWO 4'h8
`define DTM_PERIODIC_SYNC 8'hFF
`define DTM_ERR_LEN 7'h0F
`define DTM_WATCH_LEN 7'h0E
`define DTM_FIXED_LEN 7'h0D
`define DTM_MSG_W 109
`define DTM_LEN_W 7
`endif

// file: core/dtm_sync2.v
// Two flip-flop synchroniser for one pin level
module dtm_sync2 (
	input wire sys_clk_in,
	input wire sys_rst_in,
	input wire d_in,
	output reg q_out
);
	reg stage;
	// First stage is read only by the second
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			stage <= 1'b0;
			q_out <= 1'b0;
		end else begin
			stage <= d_in;
			q_out <= stage;
		end
	end
endmodule

// file: core/dtm_queue.v
// Message queue: stores message words with their lengths, in order
module dtm_queue #(
	parameter DEPTH_LOG2 = 3
) (
	input wire sys_clk_in,
	input wire sys_rst_in,
	input wire clr_in,
	input wire push_in,
	input wire [108:0] msg_in,
	input wire [6:0] len_in,
	input wire pop_in,
	output wire [108:0] msg_out,
	output wire [6:0] len_out,
	output wire empty_out,
	output wire full_out
);
	localparam DEPTH = 1 << DEPTH_LOG2;
	reg [108:0] mem_msg [0:DEPTH-1];
	reg [6:0] mem_len [0:DEPTH-1];
	reg [DEPTH_LOG2:0] wr_ptr;
	reg [DEPTH_LOG2:0] rd_ptr;
	assign empty_out = (wr_ptr == rd_ptr);
	assign full_out = (wr_ptr[DEPTH_LOG2] != rd_ptr[DEPTH_LOG2]) &&
		(wr_ptr[DEPTH_LOG2-1:0] == rd_ptr[DEPTH_LOG2-1:0]);
	assign msg_out = mem_msg[rd_ptr[DEPTH_LOG2-1:0]];
	assign len_out = mem_len[rd_ptr[DEPTH_LOG2-1:0]];
	// Storage has no reset; pointers decide what is valid
	always @(posedge sys_clk_in) begin
		if (push_in && !full_out) begin
			mem_msg[wr_ptr[DEPTH_LOG2-1:0]] <= msg_in;
			mem_len[wr_ptr[DEPTH_LOG2-1:0]] <= len_in;
		end
	end
	// Pointers
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wr_ptr <= {(DEPTH_LOG2+1){1'b0}};
			rd_ptr <= {(DEPTH_LOG2+1){1'b0}};
		end else if (clr_in) begin
			wr_ptr <= {(DEPTH_LOG2+1){1'b0}};
			rd_ptr <= {(DEPTH_LOG2+1){1'b0}};
		end else begin
			if (push_in && !full_out)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop_in && !empty_out)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// file: core/dtm_trace_unit.v
// DMA bus trace messaging: qualify, build, queue and serialise messages
//
// Functional notes
// - Trace only accesses made by the DMA engine
// - Data message: data, size, source, type, relative address
// - Full queue: discard until drained, then error
// - Error code 00010 data only, 01000 both
// - Error code 00110 when only watchpoints refused
// - Error message: 15 bits, type, source, code
// - Sync after reset and after trace enable
// - Sync after low power or debug exit
// - Sync after any queue overrun
// - Force sync after 255 unsynced messages
// - Event-in pin forces sync when permitted
// - Secure access lost, next message sync
// - Priority error, watchpoint, data; collision forces sync
// - Sync types 001101/001110 with full address
// - Test-port reset clears queue, sync, overflow and serialiser state
// - Trace enabled by mode field or watchpoint
// - One queue, sent strictly in order
// - Qualify by read/write select and range
// - Ignore aborts, fetches; drop data errors
// - Watchpoint message on either address match
// - Watchpoint message 14 bits, hit bits
// - Size 011 for eight bytes, no reserved codes
// - Size 000 byte, 001 half, 010 word
// - Plain types 5 write, 6 read
`include "dtm_defs.vh"
module dtm_trace_unit #(
	parameter DEPTH_LOG2 = 3,
	parameter MDO_W = 8,
	parameter [3:0] SOURCE_ID = 4'h0
) (
	// Clock and resets
	input wire sys_clk_in,
	input wire sys_rst_in,
	input wire test_port_reset_pin_in,
	// Configuration
	input wire module_enable_in,
	input wire [1:0] trace_mode_field_in,
	input wire trace_start_on_watch_in,
	input wire watch_msg_enable_in,
	input wire [1:0] rw_trace_select_one_in,
	input wire range_control_one_in,
	input wire [31:0] range_start_address_in,
	input wire [31:0] range_end_address_in,
	input wire watch_control_one_in,
	input wire watch_control_two_in,
	input wire [31:0] watch_address_one_in,
	input wire [31:0] watch_address_two_in,
	input wire [1:0] event_in_control_in,
	// System state
	input wire low_power_in,
	input wire debug_mode_in,
	input wire event_in_pin_in,
	// Bus snoop
	input wire bus_valid_in,
	input wire bus_dma_master_in,
	input wire bus_write_in,
	input wire bus_fetch_in,
	input wire bus_abort_signal_in,
	input wire bus_error_in,
	input wire bus_secure_in,
	input wire [2:0] bus_size_in,
	input wire [31:0] bus_addr_in,
	input wire [63:0] bus_data_in,
	// Auxiliary trace port
	output reg [MDO_W-1:0] trace_data_out_pins_out,
	output reg trace_valid_out,
	output reg trace_last_out,
	output reg trace_enabled_out
);
	// Width of a value with leading zeros removed, at least one
	function [6:0] dtm_width;
		input [63:0] v;
		integer i;
		begin
			dtm_width = 7'h01;
			for (i = 0; i < 64; i = i + 1)
				if (v[i])
					dtm_width = i[6:0] + 7'h01;
		end
	endfunction
	// Range test used for both the window and its complement
	function dtm_in_range;
		input [31:0] a;
		input [31:0] lo;
		input [31:0] hi;
		begin
			dtm_in_range = (a >= lo) && (a <= hi);
		end
	endfunction

	localparam ST_RUN = 1'b0;
	localparam ST_DRAIN = 1'b1;
	localparam TX_IDLE = 1'b0;
	localparam TX_SEND = 1'b1;

	wire evti_sync;
	wire tprst_sync;
	dtm_sync2 u_evti (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.d_in(event_in_pin_in),
		.q_out(evti_sync)
	);
	dtm_sync2 u_tprst (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.d_in(test_port_reset_pin_in),
		.q_out(tprst_sync)
	);

	reg tprst_d;
	reg evti_d;
	reg lp_d;
	reg dbg_d;
	reg trace_en;
	reg trace_en_d;
	reg watch_started;
	reg need_sync;
	reg [7:0] unsync_cnt;
	reg [31:0] last_addr;
	reg ovf_state;
	reg ref_data;
	reg ref_watch;
	reg tx_state;
	reg [108:0] tx_shift;
	reg [6:0] tx_left;

	// Negation of the test-port reset acts as a synchronous clear
	wire soft_clr = tprst_d && !tprst_sync;

	wire q_empty;
	wire q_full;
	wire [108:0] q_msg;
	wire [6:0] q_len;
	reg q_push;
	reg [108:0] q_in_msg;
	reg [6:0] q_in_len;
	wire q_pop = (tx_state == TX_IDLE) && !q_empty;

	dtm_queue #(
		.DEPTH_LOG2(DEPTH_LOG2)
	) u_queue (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.clr_in(soft_clr),
		.push_in(q_push),
		.msg_in(q_in_msg),
		.len_in(q_in_len),
		.pop_in(q_pop),
		.msg_out(q_msg),
		.len_out(q_len),
		.empty_out(q_empty),
		.full_out(q_full)
	);

	// Access qualification
	wire bus_ok = bus_valid_in && bus_dma_master_in;
	wire cycle_ok = bus_ok && !bus_fetch_in && !bus_abort_signal_in;
	wire in_win = dtm_in_range(bus_addr_in, range_start_address_in, range_end_address_in);
	wire win_ok = range_control_one_in ? !in_win : in_win;
	wire rw_ok = bus_write_in ? rw_trace_select_one_in[1] : rw_trace_select_one_in[0];
	wire hit_one = watch_control_one_in && (bus_addr_in == watch_address_one_in);
	wire hit_two = watch_control_two_in && (bus_addr_in == watch_address_two_in);
	wire watch_hit = cycle_ok && (hit_one || hit_two);
	wire trace_now = trace_en || (trace_start_on_watch_in && watch_hit);
	wire dtm_cand = cycle_ok && trace_now && win_ok && rw_ok;
	wire dtm_req = dtm_cand && !bus_error_in && !bus_secure_in;
	wire wpm_req = watch_hit && watch_msg_enable_in && module_enable_in;
	wire evti_rise = evti_sync && !evti_d;
	wire evti_ok = module_enable_in && trace_en && (event_in_control_in != 2'h0);

	// Sync decision for the current data message
	wire is_sync = need_sync || (unsync_cnt == `DTM_PERIODIC_SYNC);
	wire [31:0] rel_addr = is_sync ? bus_addr_in : (bus_addr_in ^ last_addr);
	wire [6:0] addr_w = dtm_width({32'h00000000, rel_addr});
	wire [63:0] data_val = bus_data_in;
	wire [6:0] data_w = dtm_width(data_val);
	wire [5:0] dtm_tc = bus_write_in ?
		(is_sync ? `DTM_TC_SYNC_WRITE : `DTM_TC_WRITE) :
		(is_sync ? `DTM_TC_SYNC_READ : `DTM_TC_READ);
	// Reserved size codes never leave the block; wider ones clamp to eight bytes
	wire [2:0] size_code_field = (bus_size_in > `DTM_SZ_DOUBLE) ? `DTM_SZ_DOUBLE : bus_size_in;
	wire [108:0] addr_sh = {77'h0, rel_addr} << 13;
	wire [108:0] data_sh = {45'h0, data_val} << (addr_w + `DTM_FIXED_LEN);
	wire [108:0] dtm_msg = {96'h0, size_code_field, SOURCE_ID, dtm_tc} | addr_sh | data_sh;
	wire [6:0] dtm_len = `DTM_FIXED_LEN + addr_w + data_w;

	wire [3:0] whit = (hit_one ? `DTM_WHIT_ONE : 4'h0) | (hit_two ? `DTM_WHIT_TWO : 4'h0);
	wire [4:0] error_code_field = (ref_data && ref_watch) ? `DTM_EC_BOTH :
		(ref_watch ? `DTM_EC_WATCH : `DTM_EC_DATA);
	wire err_req = (ovf_state == ST_DRAIN) && q_empty;

	// Queue entry arbitration
	always @* begin
		q_push = 1'b0;
		q_in_msg = 109'h0;
		q_in_len = 7'h00;
		if (err_req) begin
			q_push = 1'b1;
			q_in_msg = {94'h0, error_code_field, SOURCE_ID, `DTM_TC_ERROR};
			q_in_len = `DTM_ERR_LEN;
		end else if (ovf_state == ST_RUN && wpm_req) begin
			q_push = 1'b1;
			q_in_msg = {95'h0, whit, SOURCE_ID, `DTM_TC_WATCH};
			q_in_len = `DTM_WATCH_LEN;
		end else if (ovf_state == ST_RUN && dtm_req) begin
			q_push = 1'b1;
			q_in_msg = dtm_msg;
			q_in_len = dtm_len;
		end
	end

	// A push against a full queue starts the drain
	wire overrun = (ovf_state == ST_RUN) && q_push && q_full;
	wire dtm_taken = (ovf_state == ST_RUN) && !err_req && !wpm_req && dtm_req && !q_full;
	wire dtm_lost_coll = dtm_req && (err_req || (wpm_req && ovf_state == ST_RUN));
	wire dtm_lost_sec = dtm_cand && bus_secure_in;

	// Edge detectors and trace enable
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tprst_d <= 1'b0;
			evti_d <= 1'b0;
			lp_d <= 1'b0;
			dbg_d <= 1'b0;
			trace_en <= 1'b0;
			trace_en_d <= 1'b0;
			watch_started <= 1'b0;
			trace_enabled_out <= 1'b0;
		end else begin
			tprst_d <= tprst_sync;
			evti_d <= evti_sync;
			lp_d <= low_power_in;
			dbg_d <= debug_mode_in;
			trace_en_d <= trace_en;
			if (soft_clr)
				watch_started <= 1'b0;
			else if (trace_start_on_watch_in && watch_hit)
				watch_started <= 1'b1;
			trace_en <= module_enable_in &&
				((trace_mode_field_in != 2'h0) || watch_started);
			trace_enabled_out <= trace_en;
		end
	end

	// Sync bookkeeping: causes win over the clear by a taken message
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			need_sync <= 1'b1;
			unsync_cnt <= 8'h00;
			last_addr <= 32'h00000000;
		end else if (soft_clr) begin
			need_sync <= 1'b1;
			unsync_cnt <= 8'h00;
			last_addr <= 32'h00000000;
		end else begin
			if (dtm_taken) begin
				last_addr <= bus_addr_in;
				unsync_cnt <= is_sync ? 8'h00 : unsync_cnt + 8'h01;
			end
			if ((trace_en && !trace_en_d) ||
				(lp_d && !low_power_in) || (dbg_d && !debug_mode_in) ||
				overrun || (ovf_state == ST_DRAIN) ||
				(evti_rise && evti_ok) ||
				dtm_lost_sec || dtm_lost_coll)
				need_sync <= 1'b1;
			else if (dtm_taken)
				need_sync <= 1'b0;
		end
	end

	// Overflow state machine
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ovf_state <= ST_RUN;
			ref_data <= 1'b0;
			ref_watch <= 1'b0;
		end else if (soft_clr) begin
			ovf_state <= ST_RUN;
			ref_data <= 1'b0;
			ref_watch <= 1'b0;
		end else begin
			case (ovf_state)
				ST_RUN: begin
					if (overrun) begin
						ovf_state <= ST_DRAIN;
						ref_data <= dtm_req && !wpm_req;
						ref_watch <= wpm_req;
					end
				end
				default: begin
					// Refused messages during the drain are only recorded
					if (err_req) begin
						ovf_state <= ST_RUN;
						ref_data <= 1'b0;
						ref_watch <= 1'b0;
					end else begin
						if (dtm_req)
							ref_data <= 1'b1;
						if (wpm_req)
							ref_watch <= 1'b1;
					end
				end
			endcase
		end
	end

	// Serialiser: MDO_W bits per cycle, low bits first
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tx_state <= TX_IDLE;
			tx_shift <= 109'h0;
			tx_left <= 7'h00;
			trace_data_out_pins_out <= {MDO_W{1'b0}};
			trace_valid_out <= 1'b0;
			trace_last_out <= 1'b0;
		end else if (soft_clr) begin
			tx_state <= TX_IDLE;
			tx_left <= 7'h00;
			trace_data_out_pins_out <= {MDO_W{1'b0}};
			trace_valid_out <= 1'b0;
			trace_last_out <= 1'b0;
		end else begin
			case (tx_state)
				TX_IDLE: begin
					trace_valid_out <= 1'b0;
					trace_last_out <= 1'b0;
					trace_data_out_pins_out <= {MDO_W{1'b0}};
					if (q_pop) begin
						tx_shift <= q_msg;
						tx_left <= q_len;
						tx_state <= TX_SEND;
					end
				end
				default: begin
					trace_valid_out <= 1'b1;
					trace_data_out_pins_out <= tx_shift[MDO_W-1:0];
					tx_shift <= tx_shift >> MDO_W;
					if (tx_left <= MDO_W) begin
						trace_last_out <= 1'b1;
						tx_left <= 7'h00;
						tx_state <= TX_IDLE;
					end else begin
						trace_last_out <= 1'b0;
						tx_left <= tx_left - MDO_W[6:0];
					end
				end
			endcase
		end
	end
endmodule

// file: testbench/dtm_props.sv
// Trace port checks for the DMA bus trace messaging block
module dtm_props #(
	parameter MDO_W = 8,
	parameter [3:0] SOURCE_ID = 4'h0
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic [MDO_W-1:0] trace_data_out_pins_out,
	input wire logic trace_valid_out,
	input wire logic trace_last_out,
	input wire logic trace_enabled_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	logic [3:0] beats;
	wire [7:0] d = trace_data_out_pins_out[7:0];
	wire first = trace_valid_out && (beats == 4'h0);
	// Beat index inside the current message
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			beats <= 4'h0;
		else if (trace_valid_out)
			beats <= trace_last_out ? 4'h0 : beats + 4'h1;
	end
	a_last_in_beat: assert property (trace_last_out |-> trace_valid_out)
		else $error("last without valid");
	a_gap_after_last: assert property (trace_last_out |=> !trace_valid_out)
		else $error("no idle after message");
	a_beats_contig: assert property (
		trace_valid_out && !trace_last_out |=> trace_valid_out)
		else $error("message broken");
	a_max_length: assert property (trace_valid_out |-> beats <= 4'hD)
		else $error("message too long");
	a_type_legal: assert property (first |->
		d[5:0] inside {6'h05, 6'h06, 6'h08, 6'h0D, 6'h0E, 6'h0F})
		else $error("bad type code");
	a_source_field: assert property (first |->
		d[7:6] == SOURCE_ID[1:0] ##1 d[1:0] == SOURCE_ID[3:2])
		else $error("bad source field");
	a_error_form: assert property (first && d[5:0] == 6'h08 |=>
		trace_last_out && !d[7] && d[6:2] inside {5'h02, 5'h06, 5'h08})
		else $error("bad error message");
	a_watch_form: assert property (first && d[5:0] == 6'h0F |=>
		trace_last_out && d[3:2] == 2'h0 && d[5:4] != 2'h0 && d[7:6] == 2'h0)
		else $error("bad watch message");
	a_size_legal: assert property (
		first && d[5:0] inside {6'h05, 6'h06, 6'h0D, 6'h0E} |=> !d[4])
		else $error("reserved size code");
	a_quiet_after_reset: assert property (
		$past(sys_rst_in) |-> !trace_valid_out && !trace_enabled_out)
		else $error("active after reset");
	c_error: cover property (first && d[5:0] == 6'h08);
	c_watch: cover property (first && d[5:0] == 6'h0F);
	c_sync: cover property (first && d[5:0] inside {6'h0D, 6'h0E});
endmodule

// file: testbench/dtm_tool_model.sv
// Development tool side: gathers trace beats into whole messages
module dtm_tool_model #(
	parameter MDO_W = 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [MDO_W-1:0] data_in,
	input wire logic valid_in,
	input wire logic last_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [115:0] q[$];
	logic [111:0] acc;
	int n;
	// Least significant beat first; the tool never stalls the port
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			n = 0;
			acc = '0;
		end else if (valid_in) begin
			acc = acc | (112'(data_in) << (MDO_W * n));
			n = n + 1;
			if (last_in) begin
				q.push_back({4'(n), acc});
				n = 0;
				acc = '0;
			end
		end
	end
endmodule

// file: testbench/tb_dma_bus_trace_messaging.sv
// Self-checking bench for the DMA bus trace messaging block
module tb_dma_bus_trace_messaging;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in = 0, sys_rst_in = 1, test_port_reset_pin_in = 0, module_enable_in = 1;
	logic [1:0] trace_mode_field_in = 2'h1, rw_trace_select_one_in = 2'h3, event_in_control_in = 2'h0;
	logic trace_start_on_watch_in = 0, watch_msg_enable_in = 0, range_control_one_in = 0;
	logic watch_control_one_in = 1, watch_control_two_in = 1, low_power_in = 0, debug_mode_in = 0;
	logic event_in_pin_in = 0, bus_valid_in = 0, bus_dma_master_in = 1, bus_write_in = 0;
	logic bus_fetch_in = 0, bus_abort_signal_in = 0, bus_error_in = 0, bus_secure_in = 0;
	logic [2:0] bus_size_in = 3'h0;
	logic [31:0] range_start_address_in = 32'h0, range_end_address_in = 32'hFFFFFFFF;
	logic [31:0] watch_address_one_in = 32'h200, watch_address_two_in = 32'h300;
	logic [31:0] bus_addr_in = 32'h0, la = 32'h0;
	logic [63:0] bus_data_in = 64'h0;
	logic [7:0] trace_data_out_pins_out;
	logic trace_valid_out, trace_last_out, trace_enabled_out;
	logic [115:0] m;
	int errors = 0, tests_run = 0;
	dtm_trace_unit #(.DEPTH_LOG2(2)) dut (.*);
	dtm_tool_model #(.MDO_W(8)) tool (.clk_in(sys_clk_in), .rst_in(sys_rst_in),
		.data_in(trace_data_out_pins_out), .valid_in(trace_valid_out), .last_in(trace_last_out));
	// Free running system clock
	initial begin
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	task automatic cmp(string what, logic [115:0] e, logic [115:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wrap_up;
		if (errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One bus cycle; f is {secure, error, abort, fetch, other master}
	task automatic acc(logic w, logic [31:0] a, logic [63:0] d, logic [2:0] sz,
		logic [4:0] f = 5'h0, bit keep = 0);
		@(posedge sys_clk_in);
		bus_valid_in <= 1;
		bus_write_in <= w;
		bus_addr_in <= a;
		bus_data_in <= d;
		bus_size_in <= sz;
		{bus_secure_in, bus_error_in, bus_abort_signal_in, bus_fetch_in} <= f[4:1];
		bus_dma_master_in <= !f[0];
		if (!keep) begin
			@(posedge sys_clk_in);
			bus_valid_in <= 0;
		end
	endtask
	// Bounded wait for the next whole message at the tool
	task automatic get(output logic [115:0] g);
		for (int i = 0; i < 600 && tool.q.size() == 0; i++) @(posedge sys_clk_in);
		if (tool.q.size() == 0) begin
			errors++;
			wrap_up();
		end
		g = tool.q.pop_front();
	endtask
	function automatic int wd(logic [63:0] v);
		wd = 1;
		for (int i = 0; i < 64; i++) if (v[i]) wd = i + 1;
	endfunction
	// Expected data message with leading zeros trimmed, beat count on top
	function automatic logic [115:0] mk(logic [5:0] t, logic [2:0] sz, logic [31:0] a,
		logic [63:0] d);
		int n;
		mk = '0;
		mk[5:0] = t;
		mk[12:10] = sz;
		mk[111:0] = mk[111:0] | (112'(a) << 13);
		n = 13 + wd({32'h0, a});
		mk[111:0] = mk[111:0] | (112'(d) << n);
		mk[115:112] = 4'((n + wd(d) + 7) / 8);
	endfunction
	// Fixed two-beat message: watch hit or error code after the source
	function automatic logic [115:0] fx(logic [5:0] t, logic [4:0] f);
		fx = '0;
		fx[5:0] = t;
		fx[14:10] = f;
		fx[115:112] = 4'h2;
	endfunction
	task automatic tr(logic w, logic [31:0] a, logic [63:0] d, logic [2:0] sz, bit s);
		acc(w, a, d, sz);
		get(m);
		cmp("data msg", mk(s ? (w ? 6'h0D : 6'h0E) : (w ? 6'h05 : 6'h06), sz, s ? a : a ^ la, d), m);
		la = a;
	endtask
	task automatic ex(logic [31:0] a, logic [115:0] e);
		acc(1, a, 64'h1, 3'h0);
		get(m);
		cmp("fixed msg", e, m);
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge sys_clk_in);
		sys_rst_in <= 0;
		repeat (3) @(posedge sys_clk_in);
		tr(1, 32'h100, 64'hAB, 3'h0, 1);
		tr(0, 32'h104, 64'h1234, 3'h1, 0);
		for (int i = 0; i < 4; i++)
			tr(1, 32'h110 + i, 64'h5 << (8 * i), 3'(i), 0);
		// Reserved size code must leave the block as eight bytes
		acc(1, 32'h118, 64'h9, 3'h6);
		get(m);
		cmp("size clamp", mk(6'h05, 3'h3, 32'h118 ^ la, 64'h9), m);
		la = 32'h118;
		for (int i = 0; i < 5; i++) acc(1, 32'h120, 64'h7, 3'h0, 5'(1 << i));
		tr(0, 32'h124, 64'h9, 3'h0, 1);
		range_control_one_in <= 1;
		range_start_address_in <= 32'h1000;
		range_end_address_in <= 32'h1FFF;
		acc(1, 32'h1800, 64'h1, 3'h0);
		tr(1, 32'h2000, 64'h2, 3'h0, 0);
		rw_trace_select_one_in <= 2'h2;
		acc(0, 32'h2004, 64'h3, 3'h0);
		tr(1, 32'h2008, 64'h4, 3'h0, 0);
		rw_trace_select_one_in <= 2'h3;
		watch_msg_enable_in <= 1;
		ex(32'h200, fx(6'h0F, 5'h4));
		ex(32'h300, fx(6'h0F, 5'h8));
		tr(1, 32'h204, 64'h6, 3'h0, 1);
		event_in_control_in <= 2'h1;
		for (int i = 0; i < 3; i++) begin
			tr(1, 32'h210, 64'h1, 3'h0, 0);
			{event_in_pin_in, debug_mode_in, low_power_in} <= 3'(1 << i);
			repeat (4) @(posedge sys_clk_in);
			{event_in_pin_in, debug_mode_in, low_power_in} <= 3'h0;
			repeat (4) @(posedge sys_clk_in);
			tr(1, 32'h214, 64'h1, 3'h0, 1);
		end
		for (int i = 0; i < 256; i++) tr(1, 32'h240, 64'h1, 3'h0, i == 255);
		// Depth four queue; back-to-back bursts outrun the port
		for (int k = 0; k < 3; k++) begin
			trace_mode_field_in <= k ? 2'h1 : 2'h0;
			repeat (3) @(posedge sys_clk_in);
			// Looked at off the edge, once the enable has settled
			#1 cmp("trace enable", k != 0, trace_enabled_out);
			for (int i = 0; i < 16; i++)
				acc(1, (k == 2 || (k == 1 && i[0])) ? 32'h250 : 32'h200, 64'h3, 3'h0, 5'h0, i < 15);
			repeat (300) @(posedge sys_clk_in);
			m = '0;
			while (tool.q.size() > 0 && m[5:0] !== 6'h08) m = tool.q.pop_front();
			cmp("overflow", fx(6'h08, k == 0 ? 5'h06 : (k == 1 ? 5'h08 : 5'h02)), m);
			tool.q.delete();
		end
		tr(1, 32'h260, 64'h1, 3'h0, 1);
		trace_mode_field_in <= 2'h0;
		trace_start_on_watch_in <= 1;
		repeat (3) @(posedge sys_clk_in);
		ex(32'h200, fx(6'h0F, 5'h4));
		tr(1, 32'h270, 64'h1, 3'h0, 1);
		tr(1, 32'h274, 64'h1, 3'h0, 0);
		trace_mode_field_in <= 2'h1;
		test_port_reset_pin_in <= 1;
		repeat (4) @(posedge sys_clk_in);
		test_port_reset_pin_in <= 0;
		repeat (6) @(posedge sys_clk_in);
		tr(1, 32'h278, 64'h1, 3'h0, 1);
		wrap_up();
	end
endmodule
bind dtm_trace_unit dtm_props #(.MDO_W(MDO_W), .SOURCE_ID(SOURCE_ID)) u_props (
	.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
	.trace_data_out_pins_out(trace_data_out_pins_out), .trace_valid_out(trace_valid_out),
	.trace_last_out(trace_last_out), .trace_enabled_out(trace_enabled_out));
